//--- ptc_pkg.sv
`default_nettype none
package ptc_pkg;
    localparam int PTC_PAIRS = 2;
    localparam int PTC_AW = 8;
    // Register offsets inside one pair window
    localparam logic [4:0] PTC_OFF_LMODE = 5'h00;
    localparam logic [4:0] PTC_OFF_UMODE = 5'h04;
    localparam logic [4:0] PTC_OFF_LDATA = 5'h08;
    localparam logic [4:0] PTC_OFF_UDATA = 5'h0C;
    localparam logic [4:0] PTC_OFF_PER = 5'h10;
    localparam logic [4:0] PTC_OFF_DUTY = 5'h14;
    localparam logic [4:0] PTC_OFF_HIGH = 5'h18;
    // Global registers
    localparam logic [7:0] PTC_ADDR_PSEL0 = 8'h40;
    localparam logic [7:0] PTC_ADDR_PSEL1 = 8'h44;
    localparam logic [7:0] PTC_ADDR_EDGE = 8'h48;
    localparam logic [7:0] PTC_ADDR_STAT = 8'h4C;
    localparam logic [7:0] PTC_RST_BYTE = 8'h00;
    localparam logic [9:0] PTC_RST_TEN = 10'h000;
    // Event clock source code of the lower clock select
    localparam logic [2:0] PTC_SEL_EVENT = 3'h7;
    localparam logic [1:0] PTC_SEL_CHAIN = 2'h3;
    // Prescaler exponents: ratio = 2**k, four bits per entry
    localparam logic [27:0] PTC_LO_KTAB = 28'hB975321;
    localparam logic [11:0] PTC_UP_KTAB = 12'h310;
    // Edge select codes, two bits per pair
    localparam int PTC_EDGE_FALL = 0;
    localparam int PTC_EDGE_RISE = 1;
    // Status bit positions
    localparam int PTC_ST_CAP = 4;
    localparam int PTC_ST_W = 6;
    typedef struct packed {
        logic [2:0] spare;
        logic capSel;
        logic run;
        logic [2:0] clkSel;
    } ptc_lower_mode_t;
    typedef struct packed {
        logic spare;
        logic wide;
        logic dutyPol;
        logic pwmMode;
        logic capSel;
        logic run;
        logic [1:0] clkSel;
    } ptc_upper_mode_t;
    typedef struct packed {
        logic [1:0] compareOut;
        logic [1:0] pwmOut;
    } ptc_pins_t;
endpackage : ptc_pkg
`default_nettype wire

//--- ptc_paired_timer.sv
`default_nettype none
module ptc_paired_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] eventCountPin,
    input wire logic [1:0] externalCapturePin,
    output ptc_pkg::ptc_pins_t pins
);
    // Bus strobes and window decode
    wire wrAcc = psel & penable & pwrite;
    wire inPair = (paddr[7:6] == 2'b00);
    wire pairIdx = paddr[5];
    wire [4:0] off = paddr[4:0];

    // Shared prescaler
    logic [10:0] preReg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            preReg <= '0;
        end else if (ce) begin
            preReg <= preReg + 11'h001;
        end
    end

    // Tick when the low k prescaler bits are all ones, so
    // every ratio is a power of two and ticks stay aligned
    function automatic logic preTick(input logic [10:0] pre, input logic [3:0] k);
        logic [11:0] m;
        m = (12'h001 << k) - 12'h001;
        return &(pre | ~m[10:0]);
    endfunction : preTick

    // Two flop synchronisers and one edge stage for pins
    // Only the second stage feeds logic; the third only holds
    // its old value for edge detection
    logic [1:0] evS1, evS2, evS3, cpS1, cpS2, cpS3;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evS1 <= '0;
            evS2 <= '0;
            evS3 <= '0;
            cpS1 <= '0;
            cpS2 <= '0;
            cpS3 <= '0;
        end else if (ce) begin
            evS1 <= eventCountPin;
            evS2 <= evS1;
            evS3 <= evS2;
            cpS1 <= externalCapturePin;
            cpS2 <= cpS1;
            cpS3 <= cpS2;
        end
    end

    // Global registers
    // Enables for the pin outputs and the capture edge choice
    logic [7:0] portSel0Reg, portSel1Reg, edgeSelReg;
    logic [ptc_pkg::PTC_ST_W-1:0] statusReg, statusSet;
    wire wrPs0 = wrAcc && paddr == ptc_pkg::PTC_ADDR_PSEL0;
    wire wrPs1 = wrAcc && paddr == ptc_pkg::PTC_ADDR_PSEL1;
    wire wrEdge = wrAcc && paddr == ptc_pkg::PTC_ADDR_EDGE;
    wire wrStat = wrAcc && paddr == ptc_pkg::PTC_ADDR_STAT;
    wire [ptc_pkg::PTC_ST_W-1:0] statClr = wrStat ? pwdata[ptc_pkg::PTC_ST_W-1:0] : '0;

    // Port select, edge select and sticky event flags; a new event beats a clear
    // Status is write one to clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portSel0Reg <= ptc_pkg::PTC_RST_BYTE;
            portSel1Reg <= ptc_pkg::PTC_RST_BYTE;
            edgeSelReg <= ptc_pkg::PTC_RST_BYTE;
            statusReg <= '0;
        end else if (ce) begin
            if (wrPs0) begin
                portSel0Reg <= pwdata[7:0];
            end
            if (wrPs1) begin
                portSel1Reg <= pwdata[7:0];
            end
            if (wrEdge) begin
                edgeSelReg <= pwdata[7:0];
            end
            statusReg <= (statusReg & ~statClr) | statusSet;
        end
    end

    // Per pair readback values
    logic [7:0] lModeV [2];
    logic [7:0] uModeV [2];
    logic [7:0] lDataV [2];
    logic [7:0] uDataV [2];
    logic [7:0] perV [2];
    logic [7:0] dutyV [2];
    logic [7:0] highV [2];

    // One generate pass per pair; nothing is shared between
    // pairs except the prescaler and the global registers
    // pairs independent
    genvar p;
    generate
        for (p = 0; p < ptc_pkg::PTC_PAIRS; p++) begin : pair
            logic [7:0] lModeReg, uModeReg, lMatchReg, uMatchReg;
            logic [7:0] perReg, dutyReg, highReg, capLoReg, capHiReg;
            logic [7:0] loCnt;
            logic [9:0] upCnt, dutyActReg;
            logic cmpReg, pwmReg;
            ptc_pkg::ptc_lower_mode_t lm;
            ptc_pkg::ptc_upper_mode_t um;
            assign lm = lModeReg;
            assign um = uModeReg;

            // Pair select; write strobe only for this window
            wire sel = (pairIdx == 1'(p)) && inPair;
            wire wrHere = wrAcc && sel;
            wire evRise = evS2[p] & ~evS3[p];
            wire cpRise = cpS2[p] & ~cpS3[p];
            wire cpFall = ~cpS2[p] & cpS3[p];
            wire capEv = (cpRise & edgeSelReg[2*p+ptc_pkg::PTC_EDGE_RISE])
                       | (cpFall & edgeSelReg[2*p+ptc_pkg::PTC_EDGE_FALL]);

            // Chained only with both upper select bits and wide bit
            wire wide = um.wide && um.clkSel == ptc_pkg::PTC_SEL_CHAIN;
            wire [3:0] loK = ptc_pkg::PTC_LO_KTAB[4*lm.clkSel +: 4];
            wire [3:0] upK = ptc_pkg::PTC_UP_KTAB[4*um.clkSel +: 4];
            // lower clock source, event pin edges at select code 7, else prescaler ticks
            wire loTick = lm.run & ce & ((lm.clkSel == ptc_pkg::PTC_SEL_EVENT)
                        ? evRise : preTick(preReg, loK));
            wire upTick = um.run & ce & ~wide & (um.clkSel != ptc_pkg::PTC_SEL_CHAIN)
                        & preTick(preReg, upK);
            wire match16 = {upCnt[7:0], loCnt} == {uMatchReg, lMatchReg};
            wire loMatch = wide ? match16 : (loCnt == lMatchReg);
            wire upMatch = upCnt[7:0] == uMatchReg;
            wire [9:0] per10 = {highReg[3:2], perReg};
            wire [9:0] duty10 = {highReg[1:0], dutyReg};
            wire perMatch = upCnt == per10;

            // Capture strobes; wide capture follows the upper bit
            wire loCap = wide ? (um.capSel & capEv) : (lm.capSel & capEv);
            wire upCap = ~wide & ~um.pwmMode & um.capSel & capEv;
            // raw active phase, full duty stays active
            // Zero duty goes active only with a zero period, since the count is never below zero
            wire pwmRaw = (dutyActReg >= per10) | (upCnt < dutyActReg);

            // software registers, writable at any time
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    lModeReg <= ptc_pkg::PTC_RST_BYTE;
                    uModeReg <= ptc_pkg::PTC_RST_BYTE;
                    lMatchReg <= ptc_pkg::PTC_RST_BYTE;
                    uMatchReg <= ptc_pkg::PTC_RST_BYTE;
                    perReg <= ptc_pkg::PTC_RST_BYTE;
                    dutyReg <= ptc_pkg::PTC_RST_BYTE;
                    highReg <= ptc_pkg::PTC_RST_BYTE;
                end else if (ce && wrHere) begin
                    if (off == ptc_pkg::PTC_OFF_LMODE) begin
                        lModeReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_UMODE) begin
                        uModeReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_LDATA) begin
                        lMatchReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_UDATA) begin
                        uMatchReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_PER) begin
                        perReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_DUTY) begin
                        dutyReg <= pwdata[7:0];
                    end else if (off == ptc_pkg::PTC_OFF_HIGH) begin
                        highReg <= {4'h0, pwdata[3:0]};
                    end
                end
            end

            // Lower counter: wide chain, match in capture, capture
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    loCnt <= ptc_pkg::PTC_RST_BYTE;
                    capLoReg <= ptc_pkg::PTC_RST_BYTE;
                    capHiReg <= ptc_pkg::PTC_RST_BYTE;
                end else if (ce) begin
                    if (loCap) begin
                        capLoReg <= loCnt;
                        loCnt <= ptc_pkg::PTC_RST_BYTE;
                        if (wide) begin
                            capHiReg <= upCnt[7:0];
                        end
                    end else if (upCap) begin
                        capHiReg <= upCnt[7:0];
                    end
                    if (!loCap && loTick) begin
                        loCnt <= loMatch ? ptc_pkg::PTC_RST_BYTE : loCnt + 8'h01;
                    end
                end
            end

            // Upper counter: wide high byte, eight bit timer or pwm
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    upCnt <= ptc_pkg::PTC_RST_TEN;
                    dutyActReg <= ptc_pkg::PTC_RST_TEN;
                end else if (ce) begin
                    if (wide) begin
                        // high byte follows the low byte carry
                        if (loCap || (loTick && match16)) begin
                            upCnt <= ptc_pkg::PTC_RST_TEN;
                        end else if (loTick && loCnt == 8'hFF) begin
                            upCnt <= {2'b00, upCnt[7:0] + 8'h01};
                        end
                    end else if (upCap) begin
                        upCnt <= ptc_pkg::PTC_RST_TEN;
                    end else if (upTick && um.pwmMode) begin
                        // duty taken over at period match
                        if (perMatch) begin
                            upCnt <= ptc_pkg::PTC_RST_TEN;
                            dutyActReg <= duty10;
                        end else begin
                            upCnt <= upCnt + 10'h001;
                        end
                    end else if (upTick) begin
                        upCnt <= upMatch ? ptc_pkg::PTC_RST_TEN
                                         : {2'b00, upCnt[7:0] + 8'h01};
                    end
                end
            end

            // Compare toggle and pwm output flops
            // Pwm output is one flop behind the counter compare
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    cmpReg <= 1'b0;
                    pwmReg <= 1'b0;
                end else if (ce) begin
                    if (loTick && loMatch && !loCap) begin
                        cmpReg <= ~cmpReg;
                    end
                    pwmReg <= um.pwmMode & (um.dutyPol ? pwmRaw : ~pwmRaw);
                end
            end

            // pwm pin gated by enable, compare pin by its enable
            assign pins.pwmOut[p] = pwmReg & portSel0Reg[p];
            assign pins.compareOut[p] = cmpReg & portSel1Reg[p];
            // Event flags: lower match, upper match, capture edge
            // Upper flag stays quiet in pwm mode and while chained
            assign statusSet[2*p] = loTick & loMatch & ~loCap;
            assign statusSet[2*p+1] = upTick & ~um.pwmMode & upMatch & ~upCap;
            assign statusSet[ptc_pkg::PTC_ST_CAP+p] = capEv;
            // capture value replaces match data on read
            assign lModeV[p] = lModeReg;
            assign uModeV[p] = uModeReg;
            assign lDataV[p] = (wide ? um.capSel : lm.capSel) ? capLoReg : lMatchReg;
            assign uDataV[p] = um.capSel ? capHiReg : uMatchReg;
            assign perV[p] = perReg;
            assign dutyV[p] = dutyReg;
            assign highV[p] = highReg;
        end
    endgenerate

    // Read mux and unmapped address detection
    // Unaligned or unlisted addresses fall through to an error
    logic [7:0] rdByte;
    logic hit;
    always_comb begin
        rdByte = 8'h00;
        hit = 1'b1;
        if (inPair && off == ptc_pkg::PTC_OFF_LMODE) begin
            rdByte = lModeV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_UMODE) begin
            rdByte = uModeV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_LDATA) begin
            rdByte = lDataV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_UDATA) begin
            rdByte = uDataV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_PER) begin
            rdByte = perV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_DUTY) begin
            rdByte = dutyV[pairIdx];
        end else if (inPair && off == ptc_pkg::PTC_OFF_HIGH) begin
            rdByte = highV[pairIdx];
        end else if (paddr == ptc_pkg::PTC_ADDR_PSEL0) begin
            rdByte = portSel0Reg;
        end else if (paddr == ptc_pkg::PTC_ADDR_PSEL1) begin
            rdByte = portSel1Reg;
        end else if (paddr == ptc_pkg::PTC_ADDR_EDGE) begin
            rdByte = edgeSelReg;
        end else if (paddr == ptc_pkg::PTC_ADDR_STAT) begin
            rdByte = {2'b00, statusReg};
        end else begin
            hit = 1'b0;
        end
    end

    // Zero wait state slave; read data is a flop sampled in setup
    // Read data is taken in the setup cycle, so it stands
    // for the whole access phase without a wait state
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= '0;
        end else if (ce && psel && !penable) begin
            prdata <= {24'h000000, rdByte};
        end
    end
endmodule : ptc_paired_timer
`default_nettype wire

//--- ptc_paired_timer_assertions.sv
`default_nettype none
module ptc_paired_timer_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] eventCountPin,
    input wire logic [1:0] externalCapturePin,
    input wire ptc_pkg::ptc_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pwmEn_reg;
    logic [1:0] cmpEn_reg;
    logic wrHit;
    logic mapped;
    // Write strobe and address map decode
    assign wrHit = psel && penable && pwrite && ce;
    assign mapped = (paddr[1:0] == 2'h0) && ((paddr < 8'h40 && paddr[4:0] <= 5'h18)
        || (paddr >= 8'h40 && paddr <= 8'h4C));
    // Shadow copies of the two pin enable registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwmEn_reg <= 2'h0;
            cmpEn_reg <= 2'h0;
        end else if (wrHit) begin
            if (paddr == ptc_pkg::PTC_ADDR_PSEL0) pwmEn_reg <= pwdata[1:0];
            if (paddr == ptc_pkg::PTC_ADDR_PSEL1) cmpEn_reg <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Bus answer and error response
    a_ready_high: assert property (pready == 1'h1)
        else $error("pready not high");
    a_err_map: assert property (pslverr == (psel && penable && !mapped))
        else $error("pslverr does not match address map");
    a_rd_upper: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rd_held: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside setup");
    a_rd_unmapped: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    // Pin gating and toggle spacing
    a_cmp_gate: assert property ((pins.compareOut & ~cmpEn_reg) == 2'h0)
        else $error("compare pin driven while disabled");
    a_pwm_gate: assert property ((pins.pwmOut & ~pwmEn_reg) == 2'h0)
        else $error("pwm pin driven while disabled");
    a_cmp_space: assert property ($changed(pins.compareOut[0]) && $stable(cmpEn_reg)
        |=> $stable(pins.compareOut[0]) || $changed(cmpEn_reg))
        else $error("compare pin toggled twice in a row");
    a_pins_reset: assert property ($fell(reset) |-> pins == 4'h0)
        else $error("pins not idle after reset");
    cover property (pslverr);
    cover property ($rose(pins.compareOut[1]));
    cover property ($rose(pins.pwmOut[0]));
endmodule : ptc_paired_timer_assertions
bind ptc_paired_timer ptc_paired_timer_assertions u_chk (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventCountPin(eventCountPin), .externalCapturePin(externalCapturePin), .pins(pins)
);
`default_nettype wire

//--- ptc_pin_model.sv
`default_nettype none
module ptc_pin_model (
    input wire logic clk,
    output var logic [1:0] eventPin,
    output var logic [1:0] capturePin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels: event lines low, capture lines high
    initial begin
        eventPin = 2'h0;
        capturePin = 2'h3;
    end
    // rising edges, wide enough for the synchronisers
    task automatic pulses(input int p, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            eventPin[p] <= 1'h1;
            repeat (4) @(posedge clk);
            eventPin[p] <= 1'h0;
            repeat (3) @(posedge clk);
        end
    endtask : pulses
    // capture line level change, then a gap of hold cycles
    task automatic setCap(input int p, input logic v, input int hold);
        @(posedge clk);
        capturePin[p] <= v;
        repeat (hold) @(posedge clk);
    endtask : setCap
endmodule : ptc_pin_model
`default_nettype wire

//--- tb_paired_timer_capture_pwm.sv
`default_nettype none
module tb_paired_timer_capture_pwm;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LO_RATIO [7] = '{2, 4, 8, 32, 128, 512, 2048};
    localparam logic [7:0] PW_HI [8] = '{5, 5, 5, 5, 5, 5, 4, 4};
    localparam logic [7:0] PW_DUTY [8] = '{0, 0, 0, 0, 8'h20, 8'h20, 0, 0};
    localparam logic [7:0] PW_MODE [8] = '{8'h34, 8'h14, 8'h35, 8'h36, 8'h34, 8'h14, 8'h34, 8'h14};
    localparam int PW_RATIO [8] = '{1, 1, 2, 8, 1, 1, 1, 1};
    localparam int PW_EXP [8] = '{256, 33, 512, 2048, 289, 0, 0, 289};
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire [1:0] eventPin;
    wire [1:0] capturePin;
    ptc_pkg::ptc_pins_t pins;
    int err_total = 0;
    int n_tests = 0;
    int n;
    logic [31:0] q;
    logic er;
    ptc_paired_timer dut (
        .clk(clk), .reset(reset), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eventCountPin(eventPin), .externalCapturePin(capturePin), .pins(pins)
    );
    ptc_pin_model pinModel (.clk(clk), .eventPin(eventPin), .capturePin(capturePin));
    // Free-running clock
    always #2 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    // One bus transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'h0, a, 32'h0);
        chk($sformatf("read %h", a), e, q);
        chk($sformatf("error %h", a), {31'h0, ee}, {31'h0, er});
    endtask : rd
    // Cycles between two compare pin toggles
    task automatic gap(input int p, output int cnt);
        logic v;
        for (int i = 0; i < 3; i++) begin
            v = pins.compareOut[p];
            cnt = 0;
            while (pins.compareOut[p] === v && cnt < 5000) begin
                @(negedge clk);
                cnt++;
            end
        end
    endtask : gap
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // Watchdog against a hung run
    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        rd(8'h08, 32'h0, 1'h0);
        rd(8'h1C, 32'h0, 1'h1);
        wr(8'h28, 32'h02);
        wr(8'h20, 32'h0F);
        pinModel.pulses(1, 2);
        rd(8'h4C, 32'h0, 1'h0);
        pinModel.pulses(1, 1);
        rd(8'h4C, 32'h04, 1'h0);
        wr(8'h4C, 32'h04);
        rd(8'h4C, 32'h0, 1'h0);
        wr(8'h44, 32'h01);
        for (int k = 0; k < 7; k++) begin
            wr(8'h00, 32'h08 | k);
            gap(0, n);
            chk("lower ratio gap", LO_RATIO[k], n);
        end
        wr(8'h00, 32'h08);
        wr(8'h08, 32'h03);
        wr(8'h2C, 32'h01);
        rd(8'h2C, 32'h01, 1'h0);
        wr(8'h24, 32'h43);
        wr(8'h20, 32'h08);
        wr(8'h44, 32'h03);
        gap(0, n);
        chk("pair0 half period", 8, n);
        gap(1, n);
        chk("wide half period", 518, n);
        wr(8'h08, 32'hFF);
        wr(8'h48, 32'h01);
        wr(8'h00, 32'h18);
        wr(8'h4C, 32'hFF);
        pinModel.setCap(0, 1'h0, 20);
        pinModel.setCap(0, 1'h1, 40);
        pinModel.setCap(0, 1'h0, 8);
        apb(1'h0, 8'h08, 32'h0);
        chk("capture 62 cycles", 1, q >= 30 && q <= 32);
        rd(8'h4C, 32'h10, 1'h0);
        wr(8'h48, 32'h03);
        pinModel.setCap(0, 1'h1, 20);
        pinModel.setCap(0, 1'h0, 8);
        apb(1'h0, 8'h08, 32'h0);
        chk("capture 21 cycles", 1, q >= 9 && q <= 12);
        wr(8'h40, 32'h01);
        for (int c = 0; c < 8; c++) begin
            wr(8'h04, 32'h00);
            wr(8'h10, 32'h20);
            wr(8'h14, PW_DUTY[c]);
            wr(8'h18, PW_HI[c]);
            wr(8'h04, PW_MODE[c]);
            repeat (300 * PW_RATIO[c]) @(posedge clk);
            n = 0;
            repeat (289 * PW_RATIO[c]) begin
                @(negedge clk);
                n += (pins.pwmOut[0] === 1'h1);
            end
            chk("pwm active cycles", PW_EXP[c], n);
        end
        wr(8'h14, 32'h10);
        wr(8'h10, 32'h30);
        repeat (700) @(posedge clk);
        n = 0;
        repeat (305) begin
            @(negedge clk);
            n += (pins.pwmOut[0] === 1'h1);
        end
        chk("pwm new period", 289, n);
        wr(8'h2C, 32'h03);
        wr(8'h48, 32'h04);
        wr(8'h24, 32'h4B);
        pinModel.setCap(1, 1'h0, 300);
        pinModel.setCap(1, 1'h1, 300);
        pinModel.setCap(1, 1'h0, 8);
        apb(1'h0, 8'h2C, 32'h0);
        chk("wide capture high", 1, q);
        apb(1'h0, 8'h28, 32'h0);
        chk("wide capture low", 1, q >= 32'h2B && q <= 32'h2E);
        rd(8'h10, 32'h30, 1'h0);
        end_of_test();
    end
endmodule : tb_paired_timer_capture_pwm
`default_nettype wire
